// [logic/fcprc_pkg.sv]
`default_nettype none
package fcprc_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_GLITCH_NS   = 5;
	localparam int T_WP_NS       = 35;
	localparam int T_AS_NS       = 10;
	localparam int T_DH_NS       = 10;
	localparam int T_RD_NS       = 70;
	// Least times round up to whole cycles
	localparam int GLITCH_CYC = (T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC     = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AS_CYC     = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DH_CYC     = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC     = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W      = 4;

	// ****************************************
	// Widths and codes
	// ****************************************
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int SECT_N = 22;
	localparam int SECT_W = 5;
	localparam logic [ADDR_W-1:0] UNLOCK1_WORD  = 20'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_WORD  = 20'h002aa;
	localparam logic [ADDR_W-1:0] UNLOCK1_BYTE  = 20'h00aaa;
	localparam logic [ADDR_W-1:0] UNLOCK2_BYTE  = 20'h00555;
	localparam logic [ADDR_W-1:0] BANK_LOW_WORD = 20'h00fff;
	localparam logic [ADDR_W-1:0] BANK_LOW_BYTE = 20'h01fff;
	localparam logic [ADDR_W-1:0] ID_LOW_WORD   = 20'h000ff;
	localparam logic [ADDR_W-1:0] ID_LOW_BYTE   = 20'h0007f;
	localparam logic [ADDR_W-1:0] ID_MFR_OFS    = 20'h00000;
	localparam logic [ADDR_W-1:0] ID_DEV_WORD   = 20'h00001;
	localparam logic [ADDR_W-1:0] ID_DEV_BYTE   = 20'h00002;
	localparam logic [ADDR_W-1:0] ID_PROT_WORD  = 20'h00002;
	localparam logic [ADDR_W-1:0] ID_PROT_BYTE  = 20'h00004;
	localparam logic [DATA_W-1:0] UNLOCK1_DATA  = 16'h00aa;
	localparam logic [DATA_W-1:0] UNLOCK2_DATA  = 16'h0055;
	localparam logic [DATA_W-1:0] ID_CMD        = 16'h0090;
	localparam logic [DATA_W-1:0] RESET_CMD     = 16'h00f0;
	localparam logic [1:0]        ID_SEL_MFR    = 2'h0;
	localparam logic [1:0]        ID_SEL_DEV    = 2'h1;
	localparam logic [1:0]        ID_SEL_PROT   = 2'h2;
	localparam int HV_A6_POS      = 6;
	localparam int TIMING_ERR_BIT = 5;
	localparam int PROT_BIT       = 0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		OP_READ, OP_STATUS, OP_ID_ENTER, OP_ID_READ, OP_RESET,
		OP_HV_ID_READ, OP_PROTECT, OP_UNPROTECT, OP_TEMP_UNPROT
	} fcprc_op_t;

	typedef struct packed {
		fcprc_op_t          op;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  data;
		logic [SECT_W-1:0]  sector;
		logic [1:0]         id_sel;
	} fcprc_cmd_t;

	typedef struct packed {
		logic               rd;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  data;
	} fcprc_step_t;

	typedef struct packed {
		logic               ce_n;
		logic               oe_n;
		logic               we_n;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  dq;
		logic               dq_oe_n;
	} fcprc_bus_t;

	localparam fcprc_bus_t BUS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		addr: '0, dq: '0, dq_oe_n: 1'b1};
endpackage : fcprc_pkg
`default_nettype wire

// [logic/fcprc_bus_cycle.sv]
`timescale 1ns/100ps
`default_nettype none
module fcprc_bus_cycle (
	input  wire logic                            sys_clk_in,
	input  wire logic                            rst_in,
	input  wire logic                            start_in,
	input  wire fcprc_pkg::fcprc_step_t          step_in,
	input  wire logic [fcprc_pkg::DATA_W-1:0]    flash_dq_in,
	output var  fcprc_pkg::fcprc_bus_t           bus_out,
	output logic                                 done_out,
	output logic [fcprc_pkg::DATA_W-1:0]         rdata_out
);
	import fcprc_pkg::*;

	typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD} fcprc_phase_t;

	fcprc_phase_t       phase_r, phase_nxt;
	logic [CNT_W-1:0]   cnt_r, cnt_nxt;
	fcprc_step_t        step_r, step_nxt;
	fcprc_bus_t         bus_nxt;
	logic               done_nxt;
	logic [DATA_W-1:0]  rdata_nxt;

	// ****************************************
	// Phase sequencing
	// ****************************************
	// Setup, strobe and hold phases; the bus image follows the next phase
	always_comb begin
		phase_nxt = phase_r;
		cnt_nxt   = cnt_r;
		step_nxt  = step_r;
		done_nxt  = 1'b0;
		rdata_nxt = rdata_out;
		unique case (phase_r)
			PH_IDLE: begin
				if (start_in) begin
					step_nxt  = step_in;
					phase_nxt = PH_SETUP;
					cnt_nxt   = CNT_W'(AS_CYC - 1);
				end
			end
			PH_SETUP: begin
				if (cnt_r == '0) begin
					phase_nxt = PH_PULSE;
					cnt_nxt   = step_r.rd ? CNT_W'(RD_CYC - 1) : CNT_W'(WP_CYC - 1);
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			PH_PULSE: begin
				if (cnt_r == '0) begin
					if (step_r.rd) begin
						rdata_nxt = flash_dq_in;
					end
					phase_nxt = PH_HOLD;
					cnt_nxt   = CNT_W'(DH_CYC - 1);
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			PH_HOLD: begin
				if (cnt_r == '0) begin
					phase_nxt = PH_IDLE;
					done_nxt  = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
		endcase
		bus_nxt = BUS_IDLE;
		if (phase_nxt != PH_IDLE) begin
			bus_nxt.ce_n    = 1'b0;
			// address before strobe falls, data past its rise
			bus_nxt.addr    = step_nxt.addr;
			bus_nxt.dq      = step_nxt.rd ? '0 : step_nxt.data;
			bus_nxt.dq_oe_n = step_nxt.rd;
			bus_nxt.we_n    = !(phase_nxt == PH_PULSE && !step_nxt.rd);
			bus_nxt.oe_n    = !(phase_nxt == PH_PULSE && step_nxt.rd);
		end
	end

	// Strobes straight from flops so no decode glitch reaches the pins
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_r   <= PH_IDLE;
			cnt_r     <= '0;
			step_r    <= '0;
			bus_out   <= BUS_IDLE;
			done_out  <= 1'b0;
			rdata_out <= '0;
		end else begin
			phase_r   <= phase_nxt;
			cnt_r     <= cnt_nxt;
			step_r    <= step_nxt;
			bus_out   <= bus_nxt;
			done_out  <= done_nxt;
			rdata_out <= rdata_nxt;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	property p_wr_combo;
		!bus_out.we_n |-> !bus_out.ce_n && bus_out.oe_n && !bus_out.dq_oe_n;
	endproperty
	a_wr_combo: assert property (p_wr_combo) else $error("write strobe outside ce low oe high");

	property p_wp_width;
		$fell(bus_out.we_n) |-> (!bus_out.we_n) [*4] ##1 bus_out.we_n;
	endproperty
	a_wp_width: assert property (p_wp_width) else $error("write pulse width wrong");

	property p_addr_stable;
		!bus_out.we_n || !bus_out.oe_n |-> $stable(bus_out.addr) && !bus_out.ce_n;
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved under strobe");

	property p_data_hold;
		$rose(bus_out.we_n) |-> !bus_out.dq_oe_n && $stable(bus_out.dq) && !bus_out.ce_n;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data not held past write rise");

	property p_rd_combo;
		!bus_out.oe_n |-> bus_out.we_n && bus_out.dq_oe_n;
	endproperty
	a_rd_combo: assert property (p_rd_combo) else $error("read strobe with write or drive");
endmodule : fcprc_bus_cycle
`default_nettype wire

// [logic/fcprc_host.sv]
// Behaviour
// - Address line nine voltage selects ID reads
// - Host refuses unprotect until all sectors are protected
// - Write needs ce, we low, oe high
// - Host resets after ID mode or timeout
// - Two unlocks then bank ID command
`timescale 1ns/100ps
`default_nettype none
module fcprc_host (
	input  wire logic                             sys_clk_in,
	input  wire logic                             rst_in,
	input  wire logic                             cmd_valid_in,
	input  wire fcprc_pkg::fcprc_cmd_t            cmd_in,
	input  wire logic                             byte_mode_in,
	input  wire logic                             supply_lockout_in,
	input  wire logic [fcprc_pkg::DATA_W-1:0]     flash_dq_in,
	output logic                                  cmd_ready_out,
	output logic                                  rsp_valid_out,
	output logic [fcprc_pkg::DATA_W-1:0]          rsp_data_out,
	output logic                                  rsp_err_out,
	output var  fcprc_pkg::fcprc_bus_t            flash_bus_out,
	output logic                                  id_voltage_addr_line_out,
	output logic                                  reset_hv_out,
	output logic [fcprc_pkg::SECT_N-1:0]          sect_prot_out
);
	import fcprc_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_STEP, S_WAIT, S_DONE} fcprc_state_t;

	fcprc_state_t       state_r, state_nxt;
	fcprc_cmd_t         cmd_r, cmd_nxt;
	logic [1:0]         step_r, step_nxt;
	logic [1:0]         last_r, last_nxt;
	logic               pre_r, pre_nxt;
	logic               id_mode_r, id_mode_nxt;
	logic               temp_r, temp_nxt;
	logic               start_r, start_nxt;
	logic               ready_nxt, rsp_valid_nxt, rsp_err_nxt, id_hv_nxt, reset_hv_nxt;
	logic [DATA_W-1:0]  rsp_data_nxt;
	logic [SECT_N-1:0]  prot_nxt;
	logic               prot_upd, prot_val;
	logic               is_write, pre_need;
	fcprc_step_t        cur_step;
	logic               bus_done;
	logic [DATA_W-1:0]  bus_rdata;

	// ****************************************
	// Bus cycle sequence
	// ****************************************
	// Step idx of a command; an optional leading reset leaves ID mode first
	function automatic fcprc_step_t step_of(input fcprc_cmd_t c, input logic [1:0] idx,
			input logic pre, input logic bm);
		fcprc_step_t       s;
		logic [1:0]        i;
		logic [ADDR_W-1:0] u1;
		logic [ADDR_W-1:0] u2;
		logic [ADDR_W-1:0] bank;
		logic [ADDR_W-1:0] idbase;
		s      = '{rd: 1'b0, addr: '0, data: RESET_CMD};
		i      = idx - {1'b0, pre};
		u1     = bm ? UNLOCK1_BYTE : UNLOCK1_WORD;
		u2     = bm ? UNLOCK2_BYTE : UNLOCK2_WORD;
		bank   = c.addr & ~(bm ? BANK_LOW_BYTE : BANK_LOW_WORD);
		idbase = c.addr & ~(bm ? ID_LOW_BYTE : ID_LOW_WORD);
		if (!(pre && idx == 2'h0)) begin
			unique case (c.op)
				OP_READ, OP_STATUS: begin
					s = '{rd: 1'b1, addr: c.addr, data: '0};
				end
				OP_ID_ENTER: begin
					if (i == 2'h0) begin
						s = '{rd: 1'b0, addr: u1, data: UNLOCK1_DATA};
					end else if (i == 2'h1) begin
						s = '{rd: 1'b0, addr: u2, data: UNLOCK2_DATA};
					end else begin
						s = '{rd: 1'b0, addr: bank | u1, data: ID_CMD};
					end
				end
				// offsets by word or byte mode
				OP_ID_READ: begin
					s.rd   = 1'b1;
					s.data = '0;
					if (c.id_sel == ID_SEL_MFR) begin
						s.addr = bank | ID_MFR_OFS;
					end else if (c.id_sel == ID_SEL_DEV) begin
						s.addr = bank | (bm ? ID_DEV_BYTE : ID_DEV_WORD);
					end else begin
						s.addr = idbase | (bm ? ID_PROT_BYTE : ID_PROT_WORD);
					end
				end
				// A6 low, A1 and A0 pick the code
				OP_HV_ID_READ: begin
					s.rd            = 1'b1;
					s.data          = '0;
					s.addr          = {c.addr[ADDR_W-1:2], c.id_sel};
					s.addr[HV_A6_POS] = 1'b0;
				end
				OP_PROTECT, OP_UNPROTECT: begin
					s = '{rd: 1'b0, addr: c.addr, data: c.data};
				end
				default: begin
					s = '{rd: 1'b0, addr: '0, data: RESET_CMD};
				end
			endcase
		end
		return s;
	endfunction

	assign cur_step = step_of(cmd_r, step_r, pre_r, byte_mode_in);
	// leave ID mode before reading array or status
	assign pre_need = id_mode_r && (cmd_in.op == OP_READ || cmd_in.op == OP_STATUS);
	assign is_write = pre_need || !(cmd_in.op == OP_READ || cmd_in.op == OP_STATUS
		|| cmd_in.op == OP_ID_READ || cmd_in.op == OP_HV_ID_READ);

	// ****************************************
	// Command state machine
	// ****************************************
	always_comb begin
		state_nxt     = state_r;
		cmd_nxt       = cmd_r;
		step_nxt      = step_r;
		last_nxt      = last_r;
		pre_nxt       = pre_r;
		id_mode_nxt   = id_mode_r;
		temp_nxt      = temp_r;
		start_nxt     = 1'b0;
		ready_nxt     = cmd_ready_out;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt  = rsp_data_out;
		rsp_err_nxt   = rsp_err_out;
		id_hv_nxt     = id_voltage_addr_line_out;
		reset_hv_nxt  = reset_hv_out;
		prot_upd      = 1'b0;
		prot_val      = 1'b0;
		unique case (state_r)
			S_IDLE: begin
				if (cmd_valid_in && cmd_ready_out) begin
					ready_nxt    = 1'b0;
					cmd_nxt      = cmd_in;
					rsp_data_nxt = '0;
					rsp_err_nxt  = 1'b0;
					state_nxt    = S_DONE;
					if (supply_lockout_in && is_write) begin
						rsp_err_nxt = 1'b1;
					// unprotect only once every sector is protected
					end else if (cmd_in.op == OP_UNPROTECT && !(&sect_prot_out)) begin
						rsp_err_nxt = 1'b1;
					end else if (cmd_in.op == OP_ID_READ && !id_mode_r) begin
						rsp_err_nxt = 1'b1;
					// temporary unprotect holds reset pin voltage
					end else if (cmd_in.op == OP_TEMP_UNPROT) begin
						temp_nxt     = cmd_in.data[0];
						reset_hv_nxt = cmd_in.data[0];
					end else begin
						pre_nxt      = pre_need;
						step_nxt     = 2'h0;
						last_nxt     = (cmd_in.op == OP_ID_ENTER) ? 2'h2 : {1'b0, pre_need};
						// raise line nine voltage only for code reads
						id_hv_nxt    = (cmd_in.op == OP_HV_ID_READ);
						reset_hv_nxt = temp_r || cmd_in.op == OP_PROTECT
							|| cmd_in.op == OP_UNPROTECT;
						state_nxt    = S_STEP;
					end
				end
			end
			S_STEP: begin
				// abort a write step before its strobe if lockout arrived
				if (supply_lockout_in && !cur_step.rd) begin
					rsp_err_nxt = 1'b1;
					state_nxt   = S_DONE;
				end else begin
					start_nxt = 1'b1;
					state_nxt = S_WAIT;
				end
			end
			S_WAIT: begin
				if (bus_done) begin
					if (cur_step.rd) begin
						rsp_data_nxt = bus_rdata;
					end
					if (pre_r && step_r == 2'h0) begin
						id_mode_nxt = 1'b0;
					end
					state_nxt = S_STEP;
					step_nxt  = step_r + 2'h1;
					if (step_r == last_r) begin
						state_nxt = S_DONE;
						unique case (cmd_r.op)
							OP_ID_ENTER: id_mode_nxt = 1'b1;
							OP_RESET: id_mode_nxt = 1'b0;
							OP_ID_READ: begin
								prot_upd = (cmd_r.id_sel == ID_SEL_PROT);
								prot_val = bus_rdata[PROT_BIT];
							end
							OP_PROTECT: begin
								prot_upd = 1'b1;
								prot_val = 1'b1;
							end
							OP_UNPROTECT: begin
								prot_upd = 1'b1;
								prot_val = 1'b0;
							end
							OP_STATUS: begin
								if (bus_rdata[TIMING_ERR_BIT]) begin
									rsp_err_nxt = 1'b1;
									cmd_nxt.op  = OP_RESET;
									pre_nxt     = 1'b0;
									step_nxt    = 2'h0;
									last_nxt    = 2'h0;
									state_nxt   = S_STEP;
								end
							end
							default: begin
							end
						endcase
					end
				end
			end
			S_DONE: begin
				rsp_valid_nxt = 1'b1;
				ready_nxt     = 1'b1;
				id_hv_nxt     = 1'b0;
				reset_hv_nxt  = temp_r;
				state_nxt     = S_IDLE;
			end
		endcase
		// lockout flag puts the device back in array mode
		if (supply_lockout_in) begin
			id_mode_nxt = 1'b0;
		end
	end

	// Per sector protection record
	generate
		for (genvar g = 0; g < SECT_N; g++) begin : g_prot
			assign prot_nxt[g] = (prot_upd && cmd_r.sector == SECT_W'(g)) ? prot_val
				: sect_prot_out[g];
		end
	endgenerate

	// record starts unprotected; strobes idle from reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r                  <= S_IDLE;
			cmd_r                    <= '0;
			step_r                   <= '0;
			last_r                   <= '0;
			pre_r                    <= 1'b0;
			id_mode_r                <= 1'b0;
			temp_r                   <= 1'b0;
			start_r                  <= 1'b0;
			cmd_ready_out            <= 1'b1;
			rsp_valid_out            <= 1'b0;
			rsp_data_out             <= '0;
			rsp_err_out              <= 1'b0;
			id_voltage_addr_line_out <= 1'b0;
			reset_hv_out             <= 1'b0;
			sect_prot_out            <= '0;
		end else begin
			state_r                  <= state_nxt;
			cmd_r                    <= cmd_nxt;
			step_r                   <= step_nxt;
			last_r                   <= last_nxt;
			pre_r                    <= pre_nxt;
			id_mode_r                <= id_mode_nxt;
			temp_r                   <= temp_nxt;
			start_r                  <= start_nxt;
			cmd_ready_out            <= ready_nxt;
			rsp_valid_out            <= rsp_valid_nxt;
			rsp_data_out             <= rsp_data_nxt;
			rsp_err_out              <= rsp_err_nxt;
			id_voltage_addr_line_out <= id_hv_nxt;
			reset_hv_out             <= reset_hv_nxt;
			sect_prot_out            <= prot_nxt;
		end
	end

	// Pin timing engine
	fcprc_bus_cycle u_bus (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.start_in    (start_r),
		.step_in     (cur_step),
		.flash_dq_in (flash_dq_in),
		.bus_out     (flash_bus_out),
		.done_out    (bus_done),
		.rdata_out   (bus_rdata)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_read_in_id;
		id_mode_r && cmd_valid_in && cmd_ready_out && cmd_in.op == OP_READ
			&& !supply_lockout_in;
	endsequence
	sequence s_reset_strobe;
		##[1:20] (!flash_bus_out.we_n && flash_bus_out.dq[7:0] == RESET_CMD[7:0]);
	endsequence
	property p_id_exit;
		s_read_in_id |-> s_reset_strobe;
	endproperty
	a_id_exit: assert property (p_id_exit) else $error("no reset before array read");

	property p_lockout;
		supply_lockout_in && cmd_valid_in && cmd_ready_out && cmd_in.op == OP_RESET
			|=> ##1 rsp_valid_out && rsp_err_out && flash_bus_out.we_n;
	endproperty
	a_lockout: assert property (p_lockout) else $error("write accepted under lockout");

	property p_unprot;
		cmd_valid_in && cmd_ready_out && cmd_in.op == OP_UNPROTECT && !(&sect_prot_out)
			&& !supply_lockout_in |=> ##1 rsp_valid_out && rsp_err_out;
	endproperty
	a_unprot: assert property (p_unprot) else $error("unprotect not refused");

	property p_hv_id;
		!flash_bus_out.oe_n && id_voltage_addr_line_out |-> !flash_bus_out.addr[HV_A6_POS]
			&& cmd_r.op == OP_HV_ID_READ;
	endproperty
	a_hv_id: assert property (p_hv_id) else $error("id line voltage outside code read");
endmodule : fcprc_host
`default_nettype wire

// [verif/fcprc_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fcprc_flash_model #(
	parameter logic [15:0] MFR_CODE = 16'h0033, // Arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h0077  // Arbitrary value
) (
	input  wire fcprc_pkg::fcprc_bus_t bus_in,
	input  wire logic                  id_volt_in,
	input  wire logic                  reset_hv_in,
	input  wire logic                  lockout_in,
	input  wire logic                  byte_mode_in,
	input  wire logic                  timing_fault_in,
	output logic [15:0]                dq_out,
	output logic [7:0]                 viol_out
);
	import fcprc_pkg::*;
	// ****************************************
	// Device state
	// ****************************************
	// shipped unprotected
	logic [31:0] prot    = '0;
	logic        id_mode = 1'b0;
	logic        terr    = 1'b0;
	logic        wr_on   = 1'b0;
	logic [1:0]  unl     = 2'h0;
	logic [19:0] addr_l  = '0;
	logic [15:0] rd_val;
	logic [15:0] last_q  = '0;
	logic [7:0]  off;
	realtime     t_fall  = 0.0;
	initial viol_out = '0;

	// read value by mode, timing error first
	always @* begin
		off = byte_mode_in ? bus_in.addr[8:1] : bus_in.addr[7:0];
		if (terr) begin
			rd_val = 16'h0020;
		end else if (id_volt_in || id_mode) begin
			case (id_volt_in ? {6'h0, bus_in.addr[1:0]} : off)
				8'h00:   rd_val = MFR_CODE;
				8'h01:   rd_val = DEV_CODE;
				8'h02:   rd_val = {15'h0, prot[bus_in.addr[19:15]]};
				default: rd_val = 16'h0000;
			endcase
		end else begin
			rd_val = bus_in.addr[15:0] ^ 16'h5a5a;
		end
	end

	// Released bus shows the inverse so a stale sample cannot pass
	assign dq_out = (!bus_in.ce_n && !bus_in.oe_n) ? rd_val : ~last_q;
	always @(posedge bus_in.oe_n) last_q = rd_val;

	// address on the later falling strobe
	always @(negedge bus_in.we_n or negedge bus_in.ce_n) begin
		if (!bus_in.we_n && !bus_in.ce_n) begin
			addr_l = bus_in.addr;
			t_fall = $realtime;
			wr_on  = bus_in.oe_n;
			if (!bus_in.oe_n) viol_out = viol_out + 8'h01;
		end
	end

	// data on the earlier rising strobe
	always @(posedge bus_in.we_n or posedge bus_in.ce_n) begin
		if (wr_on) begin
			wr_on = 1'b0;
			if ($realtime - t_fall < 5.0) viol_out = viol_out + 8'h01;
			else if (!lockout_in) accept(bus_in.dq);
		end
	end

	task automatic accept(input logic [15:0] d);
		if (reset_hv_in) begin
			prot[addr_l[19:15]] = d[0];
		end else if (d[7:0] == 8'hf0) begin
			id_mode = 1'b0;
			terr    = 1'b0;
			unl     = 2'h0;
		end else begin
			case (unl)
				2'h0: unl = (d[7:0] == 8'haa) ? 2'h1 : 2'h0;
				2'h1: unl = (d[7:0] == 8'h55) ? 2'h2 : 2'h0;
				default: begin
					id_mode = (d[7:0] == 8'h90);
					unl     = 2'h0;
				end
			endcase
		end
	endtask : accept

	always @(posedge lockout_in) begin
		id_mode = 1'b0;
		unl     = 2'h0;
	end
	always @(posedge timing_fault_in) terr = 1'b1;
endmodule : fcprc_flash_model
`default_nettype wire

// [verif/flash_cmd_protect_reset_ctrl_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module flash_cmd_protect_reset_ctrl_bench;
	import fcprc_pkg::*;
	logic        sys_clk_in   = 1'b0;
	logic        rst_in       = 1'b1;
	logic        cmd_valid_in = 1'b0;
	fcprc_cmd_t  cmd_in       = '0;
	logic        byte_mode    = 1'b0;
	logic        lockout      = 1'b0;
	logic        fault        = 1'b0;
	logic        ready, rsp_valid, rsp_err, id_volt, rst_hv;
	logic [15:0] rsp_data, fdq;
	logic [21:0] sect_prot;
	logic [7:0]  viol;
	fcprc_bus_t  bus;
	int          fails        = 0;
	int          n_compared   = 0;

	fcprc_host dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
		.cmd_in(cmd_in), .byte_mode_in(byte_mode), .supply_lockout_in(lockout),
		.flash_dq_in(fdq), .cmd_ready_out(ready), .rsp_valid_out(rsp_valid),
		.rsp_data_out(rsp_data), .rsp_err_out(rsp_err), .flash_bus_out(bus),
		.id_voltage_addr_line_out(id_volt), .reset_hv_out(rst_hv), .sect_prot_out(sect_prot));
	fcprc_flash_model mdl (.bus_in(bus), .id_volt_in(id_volt), .reset_hv_in(rst_hv),
		.lockout_in(lockout), .byte_mode_in(byte_mode), .timing_fault_in(fault),
		.dq_out(fdq), .viol_out(viol));

	// 100 MHz clock
	initial forever #5 sys_clk_in = ~sys_clk_in;

	// One command, entered just after an edge, response judged on arrival
	task automatic run(input fcprc_op_t op, input logic [19:0] a, input logic [15:0] d,
			input logic [1:0] sel, input logic [15:0] exp_d, input logic exp_e);
		int n;
		cmd_in       = '{op: op, addr: a, data: d, sector: a[19:15], id_sel: sel};
		cmd_valid_in = 1'b1;
		@(posedge sys_clk_in);
		#1;
		cmd_valid_in = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		`CHK(rsp_valid, 1'b1)
		`CHK(rsp_data, exp_d)
		`CHK(rsp_err, exp_e)
	endtask : run

	task automatic t_reset;
		`CHK(ready, 1'b1)
		`CHK(sect_prot, 22'h0)
		run(OP_READ, 20'h00123, 16'h0, 2'h0, 16'h0123 ^ 16'h5a5a, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_ident;
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_MFR, 16'h0, 1'b1);
		run(OP_ID_ENTER, 20'h80000, 16'h0, 2'h0, 16'h0, 1'b0);
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_MFR, 16'h0033, 1'b0);
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_DEV, 16'h0077, 1'b0);
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_PROT, 16'h0, 1'b0);
		run(OP_READ, 20'h80010, 16'h0, 2'h0, 16'h0010 ^ 16'h5a5a, 1'b0);
		byte_mode = 1'b1;
		run(OP_ID_ENTER, 20'h80000, 16'h0, 2'h0, 16'h0, 1'b0);
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_DEV, 16'h0077, 1'b0);
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_PROT, 16'h0, 1'b0);
		run(OP_RESET, 20'h12345, 16'h0, 2'h0, 16'h0, 1'b0);
		byte_mode = 1'b0;
		run(OP_ID_READ, 20'h80000, 16'h0, ID_SEL_MFR, 16'h0, 1'b1);
		$display("test ident done");
	endtask : t_ident

	task automatic t_protect;
		run(OP_UNPROTECT, 20'h18000, 16'h0, 2'h0, 16'h0, 1'b1);
		for (int s = 0; s < 22; s++) begin
			run(OP_PROTECT, {s[4:0], 15'h0}, 16'h0001, 2'h0, 16'h0, 1'b0);
		end
		`CHK(sect_prot, 22'h3fffff)
		run(OP_HV_ID_READ, 20'h18000, 16'h0, ID_SEL_PROT, 16'h0001, 1'b0);
		run(OP_HV_ID_READ, 20'h00000, 16'h0, ID_SEL_MFR, 16'h0033, 1'b0);
		`CHK(id_volt, 1'b0)
		run(OP_UNPROTECT, 20'h18000, 16'h0, 2'h0, 16'h0, 1'b0);
		`CHK(sect_prot[3], 1'b0)
		run(OP_HV_ID_READ, 20'h18000, 16'h0, ID_SEL_PROT, 16'h0, 1'b0);
		run(OP_TEMP_UNPROT, 20'h0, 16'h0001, 2'h0, 16'h0, 1'b0);
		`CHK(rst_hv, 1'b1)
		run(OP_TEMP_UNPROT, 20'h0, 16'h0000, 2'h0, 16'h0, 1'b0);
		`CHK(rst_hv, 1'b0)
		$display("test protect done");
	endtask : t_protect

	task automatic t_fault;
		lockout = 1'b1;
		run(OP_RESET, 20'h0, 16'h0, 2'h0, 16'h0, 1'b1);
		lockout = 1'b0;
		run(OP_ID_ENTER, 20'h00000, 16'h0, 2'h0, 16'h0, 1'b0);
		lockout = 1'b1;
		@(posedge sys_clk_in);
		#1;
		lockout = 1'b0;
		run(OP_ID_READ, 20'h00000, 16'h0, ID_SEL_MFR, 16'h0, 1'b1);
		fault = 1'b1;
		run(OP_STATUS, 20'h00040, 16'h0, 2'h0, 16'h0020, 1'b1);
		fault = 1'b0;
		run(OP_READ, 20'h00040, 16'h0, 2'h0, 16'h0040 ^ 16'h5a5a, 1'b0);
		`CHK(viol, 8'h00)
		$display("test fault done");
	endtask : t_fault

	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	// Main sequence after four reset cycles
	initial begin
		repeat (4) @(posedge sys_clk_in);
		#1;
		rst_in = 1'b0;
		t_reset;
		t_ident;
		t_protect;
		t_fault;
		complete_run;
	end

	// Hang guard, well past the expected run of under 1000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fails++;
		complete_run;
	end
endmodule : flash_cmd_protect_reset_ctrl_bench
`default_nettype wire
